// [ext_irq.sv]
// External interrupt pin block: sync, edge detect, latch, registers
//
// Operation
// R1: Low pin per sensitivity sets request latch
// R2: Vector fetch acknowledge clears the latch
// R3: Software ack write clears latch likewise
// R4: Reset clears latch and sensitivity bit
// R5: Edge mode: falling edges set, ack clears
// R6: Level mode: clear needs ack and high
// R7: Level mode: pending while pin stays low
// R8: Ack does not block later edges
// R9: Mask withholds request, latch keeps state
// R10: Serviced request loads vector from fffa/fffb; the block presents fffa only
// R11: Pending flag reads regardless of mask
// R12: Ack bit write-only, reads zero, reset
// R13: Mask bit read/write, one disables
// R14: Sensitivity bit: zero edge, one level
// R15: Pull-up disable bit disconnects pin pull-up
// R16: Break clear enabled: ack clears during break
// R17: Break clear disabled: ack ignored in break
// R18: CPU global mask also blocks request
// R19: Software should mask in level-mode routine
// R20: Pin level offered to branch instructions
// R21: Pin synchronised; edge is high then low
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ext_irq
    import ext_irq_pkg::*;
#(
    parameter int SYNC_STAGES = 2      // Pin synchroniser depth
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // External pin, active low
    input  wire logic        irq_pin_n,
    // CPU side
    input  wire logic        vector_fetch,
    input  wire logic        cpu_global_mask,
    input  wire logic        break_state,
    input  wire logic        break_clear_enable,
    output logic             cpu_irq_req,
    output logic      [15:0] vector_addr,
    output logic             branch_if_pin_high,
    output logic             branch_if_pin_low,
    // Pad control
    output logic             pin_pullup_enable
);

    // Elaboration check on synchroniser depth
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    // Decode helper used by read and write paths
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] target);
        hit = (a == target);
    endfunction : hit

    reg_req_t   req;                 // Bundled bus request
    latch_ctl_t lctl;                // Latch cell controls
    logic [SYNC_STAGES-1:0] sync_reg; // Pin synchroniser chain
    logic       pin_prev_reg;        // Previous synced level
    logic       mode_reg;            // Sensitivity select
    logic       local_mask_bit;      // Local mask
    logic       pin_pullup_disable;  // Pull-up disable option
    logic       pending_flag;        // Latch state
    logic       sw_ack;              // Software ack pulse
    logic       ack_ok;              // Ack allowed to act
    logic       pin_low;             // Synced pin is low

    assign req = '{addr: reg_addr, wdata: reg_wdata,
                   wr: reg_wr, rd: reg_rd};

    // Synchroniser chain; stage 0 only feeds stage 1
    // Reset low: a pin held low across reset is no falling edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_reg <= '0;                             // [R4]
        end else begin
            sync_reg <= {sync_reg[SYNC_STAGES-2:0], irq_pin_n}; // [R21]
        end
    end

    // Remember last synced level for edge detection
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_prev_reg <= 1'b0;                       // [R4] [R5]
        end else begin
            pin_prev_reg <= sync_reg[SYNC_STAGES-1];    // [R21]
        end
    end

    assign pin_low = !sync_reg[SYNC_STAGES-1];

    // Software ack pulse; the bit itself is never stored
    assign sw_ack = req.wr && hit(req.addr, STATUS_CONTROL_ADDR)
                    && req.wdata[ACK_BIT];              // [R3] [R12]

    // Break protects the latch against software ack unless enabled
    assign ack_ok = vector_fetch                        // [R2]
                    || (sw_ack && (!break_state
                                   || break_clear_enable)); // [R16] [R17]

    // Controls for the latch cell
    assign lctl = '{fall: pin_prev_reg && pin_low,      // [R21]
                    low:  pin_low,
                    ack:  ack_ok,
                    mode: mode_reg};

    // Request latch
    ext_irq_req_latch u_latch (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ctl      (lctl),
        .pending  (pending_flag)
    );

    // Sensitivity select register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= STATUS_CONTROL_RESET[MODE_BIT]; // [R4] [R14]
        end else if (req.wr && hit(req.addr, STATUS_CONTROL_ADDR)) begin
            mode_reg <= req.wdata[MODE_BIT];            // [R14]
        end
    end

    // Local mask register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            local_mask_bit <= STATUS_CONTROL_RESET[MASK_BIT]; // [R13]
        end else if (req.wr && hit(req.addr, STATUS_CONTROL_ADDR)) begin
            local_mask_bit <= req.wdata[MASK_BIT];      // [R13]
        end
    end

    // Pull-up disable option register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_pullup_disable <=
                SYSTEM_OPTION_2_RESET[PULLUP_DISABLE_BIT];
        end else if (req.wr && hit(req.addr, SYSTEM_OPTION_2_ADDR)) begin
            pin_pullup_disable <= req.wdata[PULLUP_DISABLE_BIT]; // [R15]
        end
    end

    // Pad pull-up control, registered
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_pullup_enable <= 1'b1;
        end else begin
            pin_pullup_enable <= !pin_pullup_disable;   // [R15]
        end
    end

    // Request to CPU, gated by local and global masks
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_irq_req <= 1'b0;
        end else begin
            cpu_irq_req <= pending_flag && !local_mask_bit // [R9]
                           && !cpu_global_mask;         // [R18]
        end
    end

    // Vector location, presented at all times, request or not
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vector_addr <= VECTOR_HIGH_ADDR;
        end else begin
            vector_addr <= VECTOR_HIGH_ADDR;            // [R10]
        end
    end

    // Pin level for branch instructions
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            branch_if_pin_high <= 1'b1;
            branch_if_pin_low  <= 1'b0;
        end else begin
            branch_if_pin_high <= !pin_low;             // [R20]
            branch_if_pin_low  <= pin_low;              // [R20]
        end
    end

    // Read data, valid the cycle after the read strobe
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (req.rd && hit(req.addr, STATUS_CONTROL_ADDR)) begin
            reg_rdata           <= 8'h00;
            reg_rdata[MODE_BIT] <= mode_reg;
            reg_rdata[MASK_BIT] <= local_mask_bit;
            reg_rdata[ACK_BIT]  <= 1'b0;                // [R12]
            reg_rdata[FLAG_BIT] <= pending_flag;        // [R11]
        end else if (req.rd && hit(req.addr, SYSTEM_OPTION_2_ADDR)) begin
            reg_rdata                     <= 8'h00;
            reg_rdata[PULLUP_DISABLE_BIT] <= pin_pullup_disable;
        end else begin
            reg_rdata <= 8'h00;  // Unmapped or idle reads as zero
        end
    end

endmodule : ext_irq
`default_nettype wire

// [ext_irq_pkg.sv]
// Package with register map, field layout and carrier types for the IRQ block
package ext_irq_pkg;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_WIDTH_L         = 8'h08;
    localparam logic [7:0] SYSTEM_OPTION_2_ADDR = 8'h1e;
    localparam logic [7:0] STATUS_CONTROL_ADDR  = 8'h1d;

    // Field positions in ext_int_status_control
    localparam int MODE_BIT = 0;
    localparam int MASK_BIT = 1;
    localparam int ACK_BIT  = 2;
    localparam int FLAG_BIT = 3;

    // Field positions in system_option_2
    localparam int PULLUP_DISABLE_BIT = 0;

    // Reset values
    localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SYSTEM_OPTION_2_RESET = 8'h00;

    // Vector locations for this source
    localparam logic [15:0] VECTOR_HIGH_ADDR = 16'hfffa;
    localparam logic [15:0] VECTOR_LOW_ADDR  = 16'hfffb;

    // Register port request bundle
    typedef struct packed {
        logic [7:0] addr;    // Register byte address
        logic [7:0] wdata;   // Write data
        logic       wr;      // Write strobe
        logic       rd;      // Read strobe
    } reg_req_t;

    // Request latch controls fed to the latch cell
    typedef struct packed {
        logic fall;     // Falling edge seen
        logic low;      // Pin presently low
        logic ack;      // Acknowledge that is allowed to act
        logic mode;     // Level-plus-edge when one
    } latch_ctl_t;

endpackage : ext_irq_pkg

// [ext_irq_req_latch.sv]
// Request latch cell with edge and level-plus-edge clearing behaviour
`timescale 1ns/100ps
`default_nettype none
module ext_irq_req_latch
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Control
    input  wire latch_ctl_t ctl,
    // State
    output var  logic       pending
);

    logic ack_seen_reg;   // Acknowledge given while pin still low

    // Ack memory for level-plus-edge mode, so either order clears
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_seen_reg <= 1'b0;
        end else if (!pending || ctl.fall) begin
            ack_seen_reg <= 1'b0;                       // [R8]
        end else if (ctl.ack && ctl.mode) begin
            ack_seen_reg <= 1'b1;                       // [R6]
        end
    end

    // Request latch; a new edge wins over any clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pending <= 1'b0;                            // [R4]
        end else if (ctl.fall) begin
            pending <= 1'b1;                            // [R1] [R8]
        end else if (ctl.mode && ctl.low) begin
            pending <= pending;                         // [R7]
        end else if (ctl.mode) begin
            // Pin high: clear once an ack has happened, before or now
            if (ctl.ack || ack_seen_reg) begin
                pending <= 1'b0;                        // [R6]
            end
        end else if (ctl.ack) begin
            pending <= 1'b0;                            // [R5] [R2] [R3]
        end
    end

endmodule : ext_irq_req_latch
`default_nettype wire

// [ext_irq_assertions.sv]
// Port-level checker of the external interrupt block
`timescale 1ns/100ps
`default_nettype none
module ext_irq_assertions
    import ext_irq_pkg::*;
#(parameter int SYNC_STAGES = 2)
(
    // Clock, reset and register port
    input wire logic        core_clk, sys_rst, reg_wr, reg_rd,
    input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
    // Pin and CPU side
    input wire logic        irq_pin_n, vector_fetch, cpu_global_mask,
    input wire logic        break_state, break_clear_enable, cpu_irq_req,
    input wire logic [15:0] vector_addr,
    input wire logic        branch_if_pin_high, branch_if_pin_low,
    input wire logic        pin_pullup_enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Strobes decoded per register
    wire logic rd_sc  = reg_rd && reg_addr == STATUS_CONTROL_ADDR;
    wire logic wr_sc  = reg_wr && reg_addr == STATUS_CONTROL_ADDR;
    wire logic wr_opt = reg_wr && reg_addr == SYSTEM_OPTION_2_ADDR;
    wire logic ack_wr = wr_sc && reg_wdata[ACK_BIT] && !break_state;
    // Pin high long enough to flush the synchroniser
    sequence s_pin_quiet;
        irq_pin_n [*6];
    endsequence
    // Fresh falling edge, pin held low, nothing clearing
    sequence s_pin_fell;
        $fell(irq_pin_n) ##0 (!irq_pin_n && !reg_wr && !vector_fetch) [*7];
    endsequence
    AST_GLOBAL_MASK: assert property (cpu_global_mask |=> !cpu_irq_req)
        else $error("request passed the global mask");
    AST_ACK_READS_ZERO: assert property (rd_sc |=> !reg_rdata[ACK_BIT])
        else $error("acknowledge bit read as one");
    AST_FLAG_PENDING: assert property (rd_sc ##1 cpu_irq_req
        |-> reg_rdata[FLAG_BIT])
        else $error("pending flag low while request active");
    AST_MODE_MASK_RW: assert property (wr_sc ##1 !reg_wr
        ##1 rd_sc |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3))
        else $error("mode or mask did not read back");
    AST_MASK_HIDES: assert property (wr_sc && reg_wdata[MASK_BIT]
        |=> ##1 !cpu_irq_req)
        else $error("masked request still presented");
    AST_RESET_CLEARS: assert property ($fell(sys_rst)
        |-> !cpu_irq_req && pin_pullup_enable)
        else $error("request or pull-up wrong after reset");
    AST_PULLUP_CTRL: assert property (wr_opt |=> ##1
        pin_pullup_enable == !$past(reg_wdata[PULLUP_DISABLE_BIT], 2))
        else $error("pull-up control does not follow option bit");
    AST_ACK_CLEARS: assert property (s_pin_quiet ##0 ack_wr
        |=> ##1 !cpu_irq_req)
        else $error("acknowledge with pin high did not clear");
    AST_EDGE_SETS: assert property (s_pin_fell ##1 rd_sc
        |=> reg_rdata[FLAG_BIT])
        else $error("falling edge did not latch a request");
    AST_PIN_LEVEL: assert property (s_pin_fell
        |-> branch_if_pin_low && !branch_if_pin_high)
        else $error("pin level not offered to branch logic");
endmodule : ext_irq_assertions
bind ext_irq ext_irq_assertions #(.SYNC_STAGES(SYNC_STAGES))
    i_ext_irq_assertions (.*);
`default_nettype wire

// [irq_source.sv]
// Model of the external circuit on the active-low interrupt pin
`timescale 1ns/100ps
`default_nettype none
module irq_source (
    // Clock and control
    input  wire logic core_clk,
    input  wire logic pull_low,
    input  wire logic pullup_on,
    // Pin
    output logic      pin_n
);
    // Released with no pull-up: show the inverse of the last level
    logic float_reg;
    always_ff @(posedge core_clk) begin
        if (pull_low || pullup_on) begin
            float_reg <= !pin_n;
        end
    end
    // Open collector: pulls low or lets the pull-up win
    assign pin_n = pull_low ? 1'b0 : (pullup_on ? 1'b1 : float_reg);
endmodule : irq_source
`default_nettype wire

// [external_interrupt_latch_test.sv]
// Self-checking bench of the external interrupt block
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_latch_test;
    import ext_irq_pkg::*;
    // Bench signals
    logic core_clk, sys_rst, reg_wr, reg_rd, vector_fetch, cpu_global_mask;
    logic break_state, break_clear_enable, pull_low, pin_n, irq_req;
    logic branch_hi, branch_lo, pullup_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [15:0] vec;
    int mismatches = 0;
    int n_tests = 0;
    // Device and pin partner
    ext_irq i_ext_irq (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_pin_n(pin_n),
        .vector_fetch(vector_fetch), .cpu_global_mask(cpu_global_mask),
        .break_state(break_state), .break_clear_enable(break_clear_enable),
        .cpu_irq_req(irq_req), .vector_addr(vec),
        .branch_if_pin_high(branch_hi), .branch_if_pin_low(branch_lo),
        .pin_pullup_enable(pullup_en));
    irq_source i_irq_source (.core_clk(core_clk), .pull_low(pull_low),
        .pullup_on(pullup_en), .pin_n(pin_n));
    // Compare and count
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle read, data judged in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // Request line after settling
    task automatic irq(input logic e);
        cyc(4);
        #1 chk(irq_req, e);
    endtask : irq
    task automatic pin(input logic low);
        @(posedge core_clk);
        pull_low <= low;
    endtask : pin
    task automatic vf();
        @(posedge core_clk);
        vector_fetch <= 1'b1;
        @(posedge core_clk);
        vector_fetch <= 1'b0;
    endtask : vf
    // Reset values and unmapped place
    task automatic t_reset();
        rd(STATUS_CONTROL_ADDR, 8'h00);
        rd(SYSTEM_OPTION_2_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        chk(vec, 16'hfffa);
        chk(branch_hi, 1'b1);
    endtask : t_reset
    // Edge mode: set, clear with pin low, edge after ack
    task automatic t_edge();
        pin(1'b1);
        cyc(6);
        rd(STATUS_CONTROL_ADDR, 8'h08);
        chk(branch_lo, 1'b1);
        wr(STATUS_CONTROL_ADDR, 8'h04);
        irq(1'b0);
        pin(1'b0);
        cyc(4);
        pin(1'b1);
        cyc(6);
        rd(STATUS_CONTROL_ADDR, 8'h08);
        vf();
        irq(1'b0);
        pin(1'b0);
    endtask : t_edge
    // Level mode: both orders of ack and pin release
    task automatic t_level();
        wr(STATUS_CONTROL_ADDR, 8'h01);
        pin(1'b1);
        cyc(6);
        rd(STATUS_CONTROL_ADDR, 8'h09);
        vf();
        irq(1'b1);
        wr(STATUS_CONTROL_ADDR, 8'h03);
        irq(1'b0);
        pin(1'b0);
        wr(STATUS_CONTROL_ADDR, 8'h01);
        irq(1'b0);
        pin(1'b1);
        cyc(6);
        pin(1'b0);
        irq(1'b1);
        wr(STATUS_CONTROL_ADDR, 8'h05);
        irq(1'b0);
        wr(STATUS_CONTROL_ADDR, 8'h00);
    endtask : t_level
    // Local and global masking, then break protection
    task automatic t_mask_break();
        pin(1'b1);
        cyc(6);
        wr(STATUS_CONTROL_ADDR, 8'h02);
        rd(STATUS_CONTROL_ADDR, 8'h0a);
        irq(1'b0);
        wr(STATUS_CONTROL_ADDR, 8'h00);
        irq(1'b1);
        @(posedge core_clk);
        cpu_global_mask <= 1'b1;
        irq(1'b0);
        @(posedge core_clk);
        cpu_global_mask <= 1'b0;
        break_state <= 1'b1;
        wr(STATUS_CONTROL_ADDR, 8'h04);
        irq(1'b1);
        @(posedge core_clk);
        break_clear_enable <= 1'b1;
        wr(STATUS_CONTROL_ADDR, 8'h04);
        irq(1'b0);
        @(posedge core_clk);
        break_state <= 1'b0;
        irq(1'b0);
        pin(1'b0);
    endtask : t_mask_break
    // Pull-up control, then reset with pin held low
    task automatic t_pullup_reset();
        pin(1'b1);
        wr(SYSTEM_OPTION_2_ADDR, 8'h01);
        rd(SYSTEM_OPTION_2_ADDR, 8'h01);
        chk(pullup_en, 1'b0);
        wr(SYSTEM_OPTION_2_ADDR, 8'h00);
        wr(STATUS_CONTROL_ADDR, 8'h01);
        irq(1'b1);
        chk(pullup_en, 1'b1);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        irq(1'b0);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        irq(1'b0);
        rd(STATUS_CONTROL_ADDR, 8'h00);
        pin(1'b0);
    endtask : t_pullup_reset
    // Verdict and end of run
    task automatic final_report();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Watchdog well beyond the expected run
    initial begin
        #100us;
        mismatches++;
        final_report();
    end
    // Main sequence
    initial begin
        {sys_rst, reg_wr, reg_rd, vector_fetch, cpu_global_mask} = 5'h10;
        {break_state, break_clear_enable, pull_low} = 3'h0;
        {reg_addr, reg_wdata} = 16'h0000;
        cyc(5);
        sys_rst <= 1'b0;
        t_reset();
        t_edge();
        t_level();
        t_mask_break();
        t_pullup_reset();
        final_report();
    end
endmodule : external_interrupt_latch_test
`default_nettype wire
